// File: hdl/acr_fifo.sv
// Purpose: ring buffer storage for packed axis values
// Assumes: push and pop may coincide in one cycle
// Notes: head word comes out of a register, refreshed every cycle
`timescale 1ns/1ps
module acr_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 16
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH):0] count_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic [WIDTH-1:0] head_ff;
   logic [AW-1:0] nxt_rd_ptr;
   logic push;
   logic pop;

   assign in_ready_o = (count_ff != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid_o = (count_ff != '0);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign nxt_rd_ptr = pop ? rd_ptr_ff + AW'(1) : rd_ptr_ff;
   assign out_data_o = head_ff;
   assign count_o = count_ff;

   // a write into the slot that becomes the head bypasses the array
   always_ff @(posedge core_clk_i)
   begin
      if (push && wr_ptr_ff == nxt_rd_ptr)
      begin
         head_ff <= in_data_i;
      end
      else
      begin
         head_ff <= mem_ff[nxt_rd_ptr];
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (push)
      begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_ff <= wr_ptr_ff + AW'(1);
         end
         if (pop)
         begin
            rd_ptr_ff <= rd_ptr_ff + AW'(1);
         end
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         count_ff <= '0;
      end
      else if (push && !pop)
      begin
         count_ff <= count_ff + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
         count_ff <= count_ff - (AW+1)'(1);
      end
   end
endmodule

// File: hdl/acr_pkg.sv
// Purpose: constants for the accel output register readout
// Assumes: byte-wide register port, 6-bit register address
// Notes: all output registers except the mode register are read-only, reset to zero
package acr_pkg;
   localparam int ADDR_W = 6;
   localparam int ACC_W = 13;
   localparam int BUF_W = 11;
   localparam int TEMP_W = 9;
   localparam int BUF_DEPTH = 16;
   localparam int NUM_CH = 4;
   ////////////////////////////////////////////////////////////////////////
   localparam logic [ADDR_W-1:0] REG_X_LOW = 6'h04;
   localparam logic [ADDR_W-1:0] REG_X_HIGH = 6'h05;
   localparam logic [ADDR_W-1:0] REG_Y_LOW = 6'h06;
   localparam logic [ADDR_W-1:0] REG_Y_HIGH = 6'h07;
   localparam logic [ADDR_W-1:0] REG_Z_LOW = 6'h08;
   localparam logic [ADDR_W-1:0] REG_Z_HIGH = 6'h09;
   localparam logic [ADDR_W-1:0] REG_BUF_PORT = 6'h0f;
   localparam logic [ADDR_W-1:0] REG_TEMP_LOW = 6'h12;
   localparam logic [ADDR_W-1:0] REG_TEMP_HIGH = 6'h13;
   localparam logic [ADDR_W-1:0] REG_MODE = 6'h14;
   localparam logic [ADDR_W-1:0] REG_COUNT = 6'h15;
   localparam logic [ADDR_W-1:0] REG_STATUS = 6'h16;
   ////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] MODE_WMASK = 8'hd7;
   localparam int MODE_BUF_EN_BIT = 7;
   localparam int MODE_PACK8_BIT = 6;
   localparam int MODE_FFD_EN_BIT = 4;
   localparam int ST_THREE_Q_BIT = 7;
   localparam int ST_HALF_BIT = 6;
   localparam int ST_FREE_FALL_BIT = 3;
   localparam int AXIS_LOW_PAD = 3;
   localparam int BUF_LOW_PAD = 5;
   localparam int TEMP_LOW_PAD = 5;
   localparam int ACCEL_UG_PER_LSB = 750;

   typedef enum logic [2:0] {
      OPM_NORMAL = 3'b000,
      OPM_OPTIONAL = 3'b010,
      OPM_MOTION = 3'b011
   } acr_opmode_t;

   typedef enum logic [1:0] {
      PUSH_IDLE = 2'b00,
      PUSH_X = 2'b01,
      PUSH_Y = 2'b10,
      PUSH_Z = 2'b11
   } acr_push_t;
endpackage

// File: hdl/acr_readout.sv
// Purpose: output register bank and ring buffer drain of the accelerometer
// Assumes: register reads answer one cycle later; samples arrive as words
// Notes: only the mode register accepts writes
`timescale 1ns/1ps
module acr_readout
   import acr_pkg::*;
#(
   parameter int DEPTH = acr_pkg::BUF_DEPTH,
   parameter int UG_PER_LSB = acr_pkg::ACCEL_UG_PER_LSB
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [acr_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic smp_valid_i,
   output logic smp_ready_o,
   input wire logic [acr_pkg::ACC_W-1:0] smp_x_i,
   input wire logic [acr_pkg::ACC_W-1:0] smp_y_i,
   input wire logic [acr_pkg::ACC_W-1:0] smp_z_i,
   input wire logic [acr_pkg::TEMP_W-1:0] smp_temp_i,
   input wire logic free_fall_i,
   input wire logic [2:0] motion_axis_flags_i,
   output logic [15:0] accel_scale_o
);
   import acr_pkg::*;

   localparam int CW = $clog2(DEPTH) + 1;
   localparam logic [CW-1:0] HALF_LVL = CW'(DEPTH / 2);
   localparam logic [CW-1:0] THREE_Q_LVL = CW'((3 * DEPTH) / 4);
   localparam logic [ADDR_W-1:0] CH_LOW [NUM_CH] = '{REG_X_LOW, REG_Y_LOW, REG_Z_LOW, REG_TEMP_LOW};
   localparam logic [ADDR_W-1:0] CH_HIGH [NUM_CH] = '{REG_X_HIGH, REG_Y_HIGH, REG_Z_HIGH, REG_TEMP_HIGH};

   logic [ACC_W-1:0] axis_ff [3];
   logic [TEMP_W-1:0] temp_ff;
   logic [7:0] mode_ff;
   logic [7:0] live_lo [NUM_CH];
   logic [7:0] live_hi [NUM_CH];
   logic [7:0] hold_ff [NUM_CH];
   logic lock_ff [NUM_CH];
   logic free_fall_flag_ff;
   logic [2:0] motion_axis_flags_ff;
   logic buf_second_ff;
   logic [7:0] reg_rdata_ff;
   logic reg_rvalid_ff;
   acr_push_t push_state_ff;
   acr_push_t nxt_push_state;
   logic smp_take;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [BUF_W-1:0] fifo_in_data;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [BUF_W-1:0] fifo_out_data;
   logic [CW-1:0] fifo_count;
   logic buf_en;
   logic single_byte_packing_select;
   logic ffd_en;
   logic motion_mode;
   logic buf_rd;
   logic status_rd;
   logic [7:0] event_flags;
   logic [7:0] buf_byte;
   logic [7:0] nxt_rdata;

   assign buf_en = mode_ff[MODE_BUF_EN_BIT];
   assign single_byte_packing_select = mode_ff[MODE_PACK8_BIT];
   assign ffd_en = mode_ff[MODE_FFD_EN_BIT];
   assign motion_mode = (mode_ff[2:0] == OPM_MOTION);
   assign accel_scale_o = 16'(UG_PER_LSB);
   assign reg_rdata_o = reg_rdata_ff;
   assign reg_rvalid_o = reg_rvalid_ff;

   ////////////////////////////////////////////////////////////////////////
   // mode register, the only writable location here
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         mode_ff <= MODE_RESET;
      end
      else if (reg_wr_i && reg_addr_i == REG_MODE)
      begin
         mode_ff <= reg_wdata_i & MODE_WMASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // live sample words; a new sample waits until the buffer pushes are done
   assign smp_ready_o = (push_state_ff == PUSH_IDLE);
   assign smp_take = smp_valid_i & smp_ready_o;

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         axis_ff[0] <= '0;
         axis_ff[1] <= '0;
         axis_ff[2] <= '0;
         temp_ff <= '0;
      end
      else if (smp_take)
      begin
         axis_ff[0] <= smp_x_i;
         axis_ff[1] <= smp_y_i;
         axis_ff[2] <= smp_z_i;
         temp_ff <= smp_temp_i;
      end
   end

   always_comb
   begin
      for (int a = 0; a < 3; a++)
      begin
         live_hi[a] = axis_ff[a][ACC_W-1 -: 8];
         live_lo[a] = {axis_ff[a][4:0], {AXIS_LOW_PAD{1'b0}}};
      end
      live_hi[3] = {2'b00, temp_ff[8:3]};
      live_lo[3] = {temp_ff[2:0], {TEMP_LOW_PAD{1'b0}}};
   end

   ////////////////////////////////////////////////////////////////////////
   // reading a low byte freezes its high byte until the high byte is read
   for (genvar gi = 0; gi < NUM_CH; gi++)
   begin : g_ch
      always_ff @(posedge core_clk_i)
      begin
         if (srst_i)
         begin
            lock_ff[gi] <= 1'b0;
            hold_ff[gi] <= REG_RESET;
         end
         else if (reg_rd_i && reg_addr_i == CH_LOW[gi])
         begin
            lock_ff[gi] <= 1'b1;
            hold_ff[gi] <= live_hi[gi];
         end
         else if (reg_rd_i && reg_addr_i == CH_HIGH[gi])
         begin
            lock_ff[gi] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serialise one accepted sample into three buffer entries X, Y, Z
   always_comb
   begin
      nxt_push_state = push_state_ff;
      fifo_in_valid = (push_state_ff != PUSH_IDLE);
      fifo_in_data = '0;
      unique case (push_state_ff)
         PUSH_IDLE:
         begin
            if (smp_take && buf_en)
            begin
               nxt_push_state = PUSH_X;
            end
         end
         PUSH_X:
         begin
            fifo_in_data = axis_ff[0][ACC_W-1:2];
            if (fifo_in_ready)
            begin
               nxt_push_state = PUSH_Y;
            end
         end
         PUSH_Y:
         begin
            fifo_in_data = axis_ff[1][ACC_W-1:2];
            if (fifo_in_ready)
            begin
               nxt_push_state = PUSH_Z;
            end
         end
         PUSH_Z:
         begin
            fifo_in_data = axis_ff[2][ACC_W-1:2];
            if (fifo_in_ready)
            begin
               nxt_push_state = PUSH_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         push_state_ff <= PUSH_IDLE;
      end
      else
      begin
         push_state_ff <= nxt_push_state;
      end
   end

   acr_fifo #(
      .WIDTH(BUF_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_out_data),
      .count_o(fifo_count)
   );

   ////////////////////////////////////////////////////////////////////////
   // buffer port: one byte per entry, or high then low byte per entry
   assign buf_rd = reg_rd_i && reg_addr_i == REG_BUF_PORT && fifo_out_valid;
   assign fifo_pop = buf_rd && (single_byte_packing_select || buf_second_ff);

   always_comb
   begin
      if (!fifo_out_valid)
      begin
         buf_byte = REG_RESET;
      end
      else if (!single_byte_packing_select && buf_second_ff)
      begin
         buf_byte = {fifo_out_data[2:0], {BUF_LOW_PAD{1'b0}}};
      end
      else
      begin
         buf_byte = fifo_out_data[BUF_W-1 -: 8];
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         buf_second_ff <= 1'b0;
      end
      else if (reg_wr_i && reg_addr_i == REG_MODE)
      begin
         // a packing change restarts the byte pair to keep entries aligned
         buf_second_ff <= 1'b0;
      end
      else if (buf_rd && !single_byte_packing_select)
      begin
         buf_second_ff <= ~buf_second_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event flags: free-fall and motion flags sticky, cleared by a status read, a new event wins; buffer level flags follow fifo_count live
   assign status_rd = reg_rd_i && reg_addr_i == REG_STATUS;

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         free_fall_flag_ff <= 1'b0;
      end
      else
      begin
         free_fall_flag_ff <= (free_fall_i && ffd_en) || (free_fall_flag_ff && !status_rd);
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         motion_axis_flags_ff <= 3'h0;
      end
      else
      begin
         motion_axis_flags_ff <= (motion_axis_flags_i & {3{motion_mode}})
            | (motion_axis_flags_ff & {3{!status_rd}});
      end
   end

   // unavailable sources are masked at read time, so a mode change hides them
   always_comb
   begin
      event_flags = REG_RESET;
      event_flags[ST_THREE_Q_BIT] = buf_en && fifo_count >= THREE_Q_LVL;
      event_flags[ST_HALF_BIT] = buf_en && fifo_count >= HALF_LVL;
      event_flags[ST_FREE_FALL_BIT] = free_fall_flag_ff && ffd_en;
      event_flags[2:0] = motion_axis_flags_ff & {3{motion_mode}};
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses answer zero
   always_comb
   begin
      nxt_rdata = REG_RESET;
      for (int c = 0; c < NUM_CH; c++)
      begin
         if (reg_addr_i == CH_LOW[c])
         begin
            nxt_rdata = live_lo[c];
         end
         if (reg_addr_i == CH_HIGH[c])
         begin
            nxt_rdata = lock_ff[c] ? hold_ff[c] : live_hi[c];
         end
      end
      if (reg_addr_i == REG_BUF_PORT)
      begin
         nxt_rdata = buf_byte;
      end
      if (reg_addr_i == REG_MODE)
      begin
         nxt_rdata = mode_ff;
      end
      if (reg_addr_i == REG_COUNT)
      begin
         nxt_rdata = 8'(fifo_count);
      end
      if (reg_addr_i == REG_STATUS)
      begin
         nxt_rdata = event_flags;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         reg_rdata_ff <= REG_RESET;
         reg_rvalid_ff <= 1'b0;
      end
      else
      begin
         reg_rvalid_ff <= reg_rd_i;
         if (reg_rd_i)
         begin
            reg_rdata_ff <= nxt_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   AST_AXIS_LOW_PAD: assert property (
      @(posedge core_clk_i) disable iff (srst_i)
      reg_rd_i && (reg_addr_i == REG_X_LOW || reg_addr_i == REG_Z_LOW)
      |=> reg_rvalid_o && reg_rdata_o[2:0] == 3'h0)
      else $error("axis low byte pad bits not zero");

   AST_AXIS_PAIR: assert property (
      @(posedge core_clk_i) disable iff (srst_i)
      reg_rd_i && reg_addr_i == REG_Y_LOW ##1 reg_rd_i && reg_addr_i == REG_Y_HIGH
      |=> reg_rdata_o == $past(live_hi[1], 2))
      else $error("axis high byte not from same sample as low byte");

   AST_THREE_Q: assert property (
      @(posedge core_clk_i) disable iff (srst_i)
      status_rd |=> reg_rdata_o[ST_THREE_Q_BIT] == $past(buf_en && fifo_count >= THREE_Q_LVL))
      else $error("three-quarter flag wrong");

   AST_HALF: assert property (
      @(posedge core_clk_i) disable iff (srst_i)
      status_rd |=> reg_rdata_o[ST_HALF_BIT] == $past(buf_en && fifo_count >= HALF_LVL))
      else $error("half flag wrong");

   AST_FREE_FALL: assert property (
      @(posedge core_clk_i) disable iff (srst_i)
      free_fall_i && ffd_en && !reg_wr_i ##1 status_rd |=> reg_rdata_o[ST_FREE_FALL_BIT])
      else $error("free fall event lost");

   AST_MOTION_MODE: assert property (
      @(posedge core_clk_i) disable iff (srst_i)
      status_rd && !motion_mode |=> reg_rdata_o[2:0] == 3'h0)
      else $error("motion flags shown outside motion mode");

   AST_COUNT: assert property (
      @(posedge core_clk_i) disable iff (srst_i)
      reg_rd_i && reg_addr_i == REG_COUNT |=> reg_rdata_o == 8'($past(fifo_count)))
      else $error("sample count read wrong");

   AST_PACK8_POP: assert property (
      @(posedge core_clk_i) disable iff (srst_i)
      buf_rd && single_byte_packing_select && !fifo_in_valid
      |=> fifo_count == $past(fifo_count) - CW'(1))
      else $error("8-bit packing did not pop once per byte");

   AST_PACK11_PAIR: assert property (
      @(posedge core_clk_i) disable iff (srst_i)
      buf_rd && !single_byte_packing_select && !buf_second_ff && !fifo_in_valid && !reg_wr_i
      |=> fifo_count == $past(fifo_count) && buf_second_ff)
      else $error("11-bit packing popped on first byte");

   AST_RESET_ZERO: assert property (
      @(posedge core_clk_i)
      $fell(srst_i) |-> reg_rdata_o == 8'h00 && fifo_count == '0 && event_flags == 8'h00)
      else $error("outputs not zero after reset");
endmodule

// File: testbench/acr_smp_src.sv
// Purpose: sample source model feeding the readout sample port
// Assumes: one sample per send pulse, offered until taken
// Notes: idle data lines carry the inverse of the last word
`timescale 1ns/1ps
module acr_smp_src
   import acr_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic send_i,
   input wire logic [acr_pkg::ACC_W-1:0] x_i,
   input wire logic [acr_pkg::ACC_W-1:0] y_i,
   input wire logic [acr_pkg::ACC_W-1:0] z_i,
   input wire logic [acr_pkg::TEMP_W-1:0] temp_i,
   input wire logic ready_i,
   output logic valid_o,
   output logic [acr_pkg::ACC_W-1:0] x_o,
   output logic [acr_pkg::ACC_W-1:0] y_o,
   output logic [acr_pkg::ACC_W-1:0] z_o,
   output logic [acr_pkg::TEMP_W-1:0] temp_o
);
   import acr_pkg::*;

   logic [3*ACC_W+TEMP_W-1:0] word_ff;
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         valid_o <= 1'b0;
         word_ff <= '0;
      end
      else if (send_i)
      begin
         valid_o <= 1'b1;
         word_ff <= {x_i, y_i, z_i, temp_i};
      end
      else if (valid_o && ready_i)
      begin
         valid_o <= 1'b0;
      end
   end
   // stale data must not pass for fresh data at a late sample
   always_comb
   begin
      {x_o, y_o, z_o, temp_o} = valid_o ? word_ff : ~word_ff;
   end
endmodule

// File: testbench/tb_top.sv
// Purpose: register-level tests of the accel output readout
// Assumes: reads answer one cycle after the request edge
// Notes: expected buffer bytes come from a queue of stored words
`timescale 1ns/1ps
module tb_top;
   import acr_pkg::*;
   logic core_clk, srst, rd_en, wr_en, ff, vld, rdy, go, rvalid, buf_on;
   logic [5:0] addr;
   logic [7:0] wd, rdata, d, d2;
   logic [2:0] mf;
   logic [12:0] sx, sy, sz, px, py, pz;
   logic [12:0] ax [3];
   logic [8:0] st, pt;
   logic [15:0] scale;
   logic [10:0] q[$];
   int fails, checks_done, cyc;
   logic [5:0] rmap [12] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0f, 6'h12, 6'h13, 6'h15, 6'h16, 6'h0a};

   acr_readout acr_readout_inst (.core_clk_i(core_clk), .srst_i(srst), .reg_addr_i(addr), .reg_rd_i(rd_en),
      .reg_wr_i(wr_en), .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .smp_valid_i(vld),
      .smp_ready_o(rdy), .smp_x_i(px), .smp_y_i(py), .smp_z_i(pz), .smp_temp_i(pt), .free_fall_i(ff),
      .motion_axis_flags_i(mf), .accel_scale_o(scale));
   acr_smp_src acr_smp_src_inst (.core_clk_i(core_clk), .srst_i(srst), .send_i(go), .x_i(sx), .y_i(sy),
      .z_i(sz), .temp_i(st), .ready_i(rdy), .valid_o(vld), .x_o(px), .y_o(py), .z_o(pz), .temp_o(pt));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task conclude();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
      begin
         $display("TB: PASS");
      end
      else
      begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         conclude();
      end
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task rd(input logic [5:0] a, output logic [7:0] v);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1;
      v = rdata;
      chk({7'h0, rvalid}, 8'h01);
   endtask

   // low byte then high byte on consecutive edges
   task rd_pair(input logic [5:0] a, output logic [7:0] lo, output logic [7:0] hi);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      addr <= 6'(a + 6'h01);
      #1;
      lo = rdata;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1;
      hi = rdata;
   endtask

   task rc(input logic [5:0] a, input logic [7:0] e);
      rd(a, d);
      chk(d, e);
   endtask

   task wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge core_clk);
      addr <= a;
      wd <= v;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask

   // waits for the take, then lets the three pushes land
   task send(input logic [12:0] x, input logic [12:0] y, input logic [12:0] z, input logic [8:0] t);
      int n;
      ax[0] = x;
      ax[1] = y;
      ax[2] = z;
      @(posedge core_clk);
      sx <= x;
      sy <= y;
      sz <= z;
      st <= t;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      #1;
      n = 0;
      while (vld === 1'b1 && n < 40)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk({7'h0, vld}, 8'h00);
      if (buf_on)
      begin
         q.push_back(x[12:2]);
         q.push_back(y[12:2]);
         q.push_back(z[12:2]);
      end
      repeat (4) @(posedge core_clk);
   endtask

   task drain(input int n, input logic one);
      logic [10:0] e;
      for (int i = 0; i < n; i++)
      begin
         e = q.pop_front();
         rc(6'h0f, e[10:3]);
         if (!one)
         begin
            rc(6'h0f, {e[2:0], 5'h00});
         end
      end
   endtask

   task pulse(input logic f, input logic [2:0] m);
      @(posedge core_clk);
      ff <= f;
      mf <= m;
      @(posedge core_clk);
      ff <= 1'b0;
      mf <= 3'h0;
   endtask

   task axes(input logic [8:0] t);
      for (int k = 0; k < 3; k++)
      begin
         rc(6'(6'h04 + 2 * k), {ax[k][4:0], 3'h0});
         rc(6'(6'h05 + 2 * k), ax[k][12:5]);
      end
      rc(6'h12, {t[2:0], 5'h00});
      rc(6'h13, {2'h0, t[8:3]});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      srst = 1'b1;
      rd_en = 1'b0;
      wr_en = 1'b0;
      addr = 6'h00;
      wd = 8'h00;
      ff = 1'b0;
      mf = 3'h0;
      go = 1'b0;
      sx = '0;
      sy = '0;
      sz = '0;
      st = '0;
      fails = 0;
      checks_done = 0;
      cyc = 0;
      buf_on = 1'b0;
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      foreach (rmap[i]) rc(rmap[i], 8'h00);
      wr(6'h04, 8'hff);
      rc(6'h04, 8'h00);
      wr(6'h14, 8'hff);
      rc(6'h14, 8'hd7);
      wr(6'h14, 8'h00);
      chk(scale[7:0], 8'hee);
      chk(scale[15:8], 8'h02);
      $display("test reset and access done");
      send(13'h1abc, 13'h0123, 13'h1001, 9'h1a5);
      axes(9'h1a5);
      rc(6'h04, {ax[0][4:0], 3'h0});
      send(13'h0555, 13'h0aaa, 13'h1fff, 9'h0f0);
      rc(6'h05, 8'hd5);
      rc(6'h05, 8'h2a);
      rd_pair(6'h06, d, d2);
      chk(d, {ax[1][4:0], 3'h0});
      chk(d2, ax[1][12:5]);
      send(13'h0000, 13'h0000, 13'h0000, 9'h000);
      foreach (rmap[i]) rc(rmap[i], 8'h00);
      $display("test direct registers done");
      pulse(1'b1, 3'h7);
      rc(6'h16, 8'h00);
      wr(6'h14, 8'h10);
      pulse(1'b1, 3'h0);
      rc(6'h16, 8'h08);
      rc(6'h16, 8'h00);
      wr(6'h14, 8'h03);
      for (int k = 0; k < 3; k++)
      begin
         pulse(1'b0, 3'(1 << k));
         rc(6'h16, 8'(1 << k));
      end
      pulse(1'b1, 3'h0);
      rc(6'h16, 8'h00);
      $display("test event flags done");
      wr(6'h14, 8'h80);
      buf_on = 1'b1;
      for (int i = 0; i < 3; i++) send({i[3:0], 9'h0a5}, {~i[3:0], 9'h15a}, 13'(i * 499 + 1911), 9'(i));
      rc(6'h15, 8'h09);
      rc(6'h16, 8'h40);
      send(13'h1234, 13'h0f0f, 13'h10f0, 9'h011);
      rc(6'h15, 8'h0c);
      rc(6'h16, 8'hc0);
      drain(6, 1'b0);
      rc(6'h15, 8'h06);
      wr(6'h14, 8'hc0);
      drain(6, 1'b1);
      rc(6'h15, 8'h00);
      rc(6'h0f, 8'h00);
      $display("test buffer packing done");
      wr(6'h14, 8'h80);
      for (int i = 0; i < 6; i++) send({~i[3:0], 9'h13c}, {i[3:0], 9'h0c3}, 13'(i * 733 + 77), 9'(i));
      rc(6'h15, 8'h10);
      chk({7'h0, rdy}, 8'h00);
      drain(18, 1'b0);
      rc(6'h15, 8'h00);
      rc(6'h16, 8'h00);
      $display("test buffer fill done");
      conclude();
   end
endmodule
